/* File: core/tpm_consts.svh */
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH

// Reference clock.
`define TPM_CLK_PERIOD_PS 4000
`define TPM_PS_PER_MS 1000000000
`define TPM_PS_PER_NS 1000
`define TPM_MS_CYCLES ((`TPM_PS_PER_MS + `TPM_CLK_PERIOD_PS - 1) / `TPM_CLK_PERIOD_PS)

// Scan timing.
`define TPM_NORMAL_MIN_MS 7
`define TPM_NORMAL_MAX_MS 10
`define TPM_GREEN_PERIOD_MS 40

// Idle time before the slow scanning state.
`define TPM_IDLE_STEP_MS 1000
`define TPM_IDLE_MAX_S 15

// Wake pulse on the shared interrupt line.
`define TPM_WAKE_MIN_MS 2
`define TPM_WAKE_MAX_MS 5
`define TPM_WAKE_CYCLES (`TPM_WAKE_MIN_MS * `TPM_MS_CYCLES)

// Baseline calibration.
`define TPM_INIT_CAL_MS 200
`define TPM_DRIFT_SCANS 8
`define TPM_BASELINE_RESET 12'h000

// Notification pulse.
`define TPM_INT_LEAD_CYCLES 4
`define TPM_INT_PULSE_NS 1000
`define TPM_INT_PULSE_CYCLES \
    ((`TPM_INT_PULSE_NS * `TPM_PS_PER_NS + `TPM_CLK_PERIOD_PS - 1) / `TPM_CLK_PERIOD_PS)

// Drive frequency hopping.
`define TPM_FREQ_COUNT 5

`endif

/* File: core/tpm_pkg.sv */
package tpm_pkg;

    typedef enum logic [1:0] {
        TPM_NORMAL,
        TPM_GREEN,
        TPM_SLEEP
    } tpm_mode_e;

    typedef enum logic [1:0] {
        TPM_IRQ_IDLE,
        TPM_IRQ_LEAD,
        TPM_IRQ_ACTIVE
    } tpm_irq_e;

endpackage

/* File: core/tpm_sync3.sv */
module tpm_sync3 (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Asynchronous input and its filtered level.
    input wire logic i_async,
    output logic o_level
);

    logic ff1;
    logic ff2;
    logic ff3;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
        end else begin
            ff1 <= i_async;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // A change is taken only once the second and third stages agree.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_level <= 1'b0;
        end else if (ff2 == ff3) begin
            o_level <= ff3;
        end
    end

endmodule // tpm_sync3

/* File: core/tpm_tick.sv */
module tpm_tick #(
    parameter int DIV = 2
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Count enable and restart.
    input wire logic i_en,
    input wire logic i_clear,
    // One-cycle pulse every DIV enabled cycles.
    output logic o_tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] count;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (i_clear) begin
            count <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (i_en) begin
                if (count == CW'(DIV - 1)) begin
                    count <= '0;
                    o_tick <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule // tpm_tick

/* File: core/tpm_top.sv */
// Behaviour
// - In the normal state a scan starts every 7 to 10 ms, the period taken from configuration.
// - After a configured 0 to 15 s without touch, in 1 s steps, normal drops to slow scanning.
// - In the slow scanning state a scan starts every 40 ms whatever the configuration.
// - A touch seen while scanning slowly returns the block at once to the normal state.
// - The host pulls the interrupt line low, then a sleep command puts the block asleep.
// - A host-driven high on the interrupt line held for 2 to 5 ms wakes the block to normal.
// - The interrupt line is pulsed only after a touch event once coordinates are ready.
// - Polarity 0 gives a rising notification edge and polarity 1 a falling one.
// - Noise reported on the drive spectrum moves the drive to the next frequency.
// - For the first 200 ms after reset every scan result is taken as the new baseline.
// - Afterwards the baseline follows slow drift by comparing history with the current data.
`include "tpm_consts.svh"

module tpm_top import tpm_pkg::*; #(
    parameter int MS_CYCLES = `TPM_MS_CYCLES,
    parameter int WAKE_CYCLES = `TPM_WAKE_CYCLES,
    parameter int SAMPLE_W = 12,
    parameter int FREQ_COUNT = `TPM_FREQ_COUNT,
    parameter int DRIFT_SCANS = `TPM_DRIFT_SCANS
) (
    // Clock and reset.
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    // Configuration levels.
    input wire logic [3:0] I_NORMAL_PERIOD_MS,
    input wire logic [3:0] I_IDLE_SECONDS,
    input wire logic I_INT_POLARITY,
    // Command from the serial interface logic.
    input wire logic I_SLEEP_CMD,
    // Scan engine results.
    input wire logic I_SCAN_DONE,
    input wire logic I_TOUCH_DETECTED,
    input wire logic I_NOISE_DETECTED,
    input wire logic [SAMPLE_W-1:0] I_RAW_SAMPLE,
    input wire logic I_DATA_READY,
    // Shared interrupt line.
    input wire logic I_INT_IN,
    output logic O_INT_OUT,
    output logic O_INT_OE,
    // Scan control and status.
    output logic O_SCAN_START,
    output logic [1:0] O_MODE,
    output logic [$clog2(FREQ_COUNT)-1:0] O_DRIVE_FREQ,
    output logic O_FREQ_HOP,
    output logic [SAMPLE_W-1:0] O_BASELINE,
    output logic O_CALIB_DONE
);

    localparam int FREQ_W = $clog2(FREQ_COUNT);
    localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
    localparam int PULSE_W = $clog2(`TPM_INT_PULSE_CYCLES + `TPM_INT_LEAD_CYCLES + 1);
    localparam int DRIFT_W = $clog2(DRIFT_SCANS + 1);

    tpm_mode_e mode;
    tpm_irq_e irq_state;
    logic ms_tick;
    logic sec_tick;
    logic idle_clear;
    logic int_level;
    logic scan_touch;
    logic [4:0] idle_sec;
    logic idle_expired;
    logic [5:0] scan_ms;
    logic [5:0] scan_period;
    logic [WAKE_W-1:0] wake_cnt;
    logic wake;
    logic touch_prev;
    logic event_pending;
    logic notify;
    logic [PULSE_W-1:0] irq_cnt;
    logic irq_pol;
    logic [7:0] init_ms;
    logic [DRIFT_W-1:0] drift_cnt;
    logic drift_up;
    logic [SAMPLE_W-1:0] baseline;

    function automatic logic [5:0] normal_period(input logic [3:0] cfg);
        logic [5:0] value;
        value = {2'h0, cfg};
        if (value < 6'(`TPM_NORMAL_MIN_MS)) begin
            value = 6'(`TPM_NORMAL_MIN_MS);
        end else if (value > 6'(`TPM_NORMAL_MAX_MS)) begin
            value = 6'(`TPM_NORMAL_MAX_MS);
        end
        return value;
    endfunction

    tpm_tick #(
        .DIV(MS_CYCLES)
    ) u_ms_tick (
        .i_clk(I_REF_CLK),
        .i_reset_n(I_RESET_N),
        .i_en(1'b1),
        .i_clear(1'b0),
        .o_tick(ms_tick)
    );

    // The seconds divider restarts with the idle count so that idle time is whole seconds.
    tpm_tick #(
        .DIV(`TPM_IDLE_STEP_MS)
    ) u_sec_tick (
        .i_clk(I_REF_CLK),
        .i_reset_n(I_RESET_N),
        .i_en(ms_tick),
        .i_clear(idle_clear),
        .o_tick(sec_tick)
    );

    tpm_sync3 u_int_sync (
        .i_clk(I_REF_CLK),
        .i_reset_n(I_RESET_N),
        .i_async(I_INT_IN),
        .o_level(int_level)
    );

    assign scan_touch = I_SCAN_DONE & I_TOUCH_DETECTED;
    assign idle_clear = (mode != TPM_NORMAL) | scan_touch;
    assign idle_expired = idle_sec >= {1'b0, I_IDLE_SECONDS};
    assign wake = int_level & (wake_cnt == WAKE_W'(WAKE_CYCLES - 1));
    assign notify = I_DATA_READY & event_pending & (mode != TPM_SLEEP) & ~I_SLEEP_CMD;
    assign O_MODE = mode;
    assign O_BASELINE = baseline;

    // Working state.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mode <= TPM_NORMAL;
        end else begin
            unique case (mode)
                TPM_NORMAL: begin
                    if (I_SLEEP_CMD) begin
                        mode <= TPM_SLEEP;
                    end else if (!scan_touch && idle_expired) begin
                        mode <= TPM_GREEN;
                    end
                end
                TPM_GREEN: begin
                    if (I_SLEEP_CMD) begin
                        mode <= TPM_SLEEP;
                    end else if (scan_touch) begin
                        mode <= TPM_NORMAL;
                    end
                end
                TPM_SLEEP: begin
                    if (wake) begin
                        mode <= TPM_NORMAL;
                    end
                end
                default: begin
                    mode <= TPM_NORMAL;
                end
            endcase
        end
    end

    // Seconds without touch, saturating at the largest setting.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            idle_sec <= 5'h00;
        end else if (idle_clear) begin
            idle_sec <= 5'h00;
        end else if (sec_tick && idle_sec != 5'(`TPM_IDLE_MAX_S)) begin
            idle_sec <= idle_sec + 5'h01;
        end
    end

    // Scan scheduler.
    always_comb begin
        if (mode == TPM_GREEN) begin
            scan_period = 6'(`TPM_GREEN_PERIOD_MS);
        end else begin
            scan_period = normal_period(I_NORMAL_PERIOD_MS);
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            scan_ms <= 6'h00;
            O_SCAN_START <= 1'b0;
        end else if (mode == TPM_SLEEP || I_SLEEP_CMD) begin
            scan_ms <= 6'h00;
            O_SCAN_START <= 1'b0;
        end else if (mode == TPM_GREEN && scan_touch) begin
            scan_ms <= 6'h00;
            O_SCAN_START <= 1'b0;
        end else begin
            O_SCAN_START <= 1'b0;
            if (ms_tick) begin
                if (scan_ms + 6'h01 >= scan_period) begin
                    scan_ms <= 6'h00;
                    O_SCAN_START <= 1'b1;
                end else begin
                    scan_ms <= scan_ms + 6'h01;
                end
            end
        end
    end

    // Wake detection counts cycles of a continuous high while asleep.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wake_cnt <= '0;
        end else if (mode != TPM_SLEEP || !int_level) begin
            wake_cnt <= '0;
        end else if (!wake) begin
            wake_cnt <= wake_cnt + 1'b1;
        end else begin
            wake_cnt <= '0;
        end
    end

    // A touch or a lift-off marks coordinate data worth reporting; a new event beats the clear.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            touch_prev <= 1'b0;
            event_pending <= 1'b0;
        end else begin
            if (I_SCAN_DONE) begin
                touch_prev <= I_TOUCH_DETECTED;
            end
            if (mode == TPM_SLEEP) begin
                event_pending <= 1'b0;
            end else if (I_SCAN_DONE && (I_TOUCH_DETECTED || touch_prev)) begin
                event_pending <= 1'b1;
            end else if (notify) begin
                event_pending <= 1'b0;
            end
        end
    end

    // Notification pulse on the shared line.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            irq_state <= TPM_IRQ_IDLE;
            irq_cnt <= '0;
            irq_pol <= 1'b0;
            O_INT_OUT <= 1'b0;
            O_INT_OE <= 1'b0;
        end else if (I_SLEEP_CMD || mode == TPM_SLEEP) begin
            irq_state <= TPM_IRQ_IDLE;
            irq_cnt <= '0;
            O_INT_OE <= 1'b0;
        end else begin
            unique case (irq_state)
                TPM_IRQ_IDLE: begin
                    if (notify) begin
                        irq_state <= TPM_IRQ_LEAD;
                        irq_cnt <= '0;
                        irq_pol <= I_INT_POLARITY;
                        O_INT_OUT <= I_INT_POLARITY;
                        O_INT_OE <= 1'b1;
                    end else begin
                        O_INT_OE <= 1'b0;
                    end
                end
                TPM_IRQ_LEAD: begin
                    if (irq_cnt == PULSE_W'(`TPM_INT_LEAD_CYCLES - 1)) begin
                        irq_state <= TPM_IRQ_ACTIVE;
                        irq_cnt <= '0;
                        O_INT_OUT <= ~irq_pol;
                    end else begin
                        irq_cnt <= irq_cnt + 1'b1;
                    end
                end
                TPM_IRQ_ACTIVE: begin
                    if (irq_cnt == PULSE_W'(`TPM_INT_PULSE_CYCLES - 1)) begin
                        irq_state <= TPM_IRQ_IDLE;
                        irq_cnt <= '0;
                        O_INT_OUT <= irq_pol;
                        O_INT_OE <= 1'b0;
                    end else begin
                        irq_cnt <= irq_cnt + 1'b1;
                    end
                end
                default: begin
                    irq_state <= TPM_IRQ_IDLE;
                    O_INT_OE <= 1'b0;
                end
            endcase
        end
    end

    // Drive frequency selection.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_DRIVE_FREQ <= '0;
            O_FREQ_HOP <= 1'b0;
        end else begin
            O_FREQ_HOP <= 1'b0;
            if (I_SCAN_DONE && I_NOISE_DETECTED && mode != TPM_SLEEP) begin
                O_FREQ_HOP <= 1'b1;
                if (O_DRIVE_FREQ == FREQ_W'(FREQ_COUNT - 1)) begin
                    O_DRIVE_FREQ <= '0;
                end else begin
                    O_DRIVE_FREQ <= O_DRIVE_FREQ + 1'b1;
                end
            end
        end
    end

    // Initial calibration window measured in milliseconds from reset.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            init_ms <= 8'h00;
            O_CALIB_DONE <= 1'b0;
        end else if (!O_CALIB_DONE && ms_tick) begin
            if (init_ms == 8'(`TPM_INIT_CAL_MS - 1)) begin
                O_CALIB_DONE <= 1'b1;
            end else begin
                init_ms <= init_ms + 8'h01;
            end
        end
    end

    // Baseline: copied during calibration, then stepped by one after a run of same-sign drift.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            baseline <= SAMPLE_W'(`TPM_BASELINE_RESET);
            drift_cnt <= '0;
            drift_up <= 1'b0;
        end else if (I_SCAN_DONE && !O_CALIB_DONE) begin
            baseline <= I_RAW_SAMPLE;
            drift_cnt <= '0;
        end else if (I_SCAN_DONE && !I_TOUCH_DETECTED) begin
            if (I_RAW_SAMPLE == baseline) begin
                drift_cnt <= '0;
            end else if ((I_RAW_SAMPLE > baseline) != drift_up || drift_cnt == '0) begin
                drift_up <= I_RAW_SAMPLE > baseline;
                drift_cnt <= DRIFT_W'(1);
            end else if (drift_cnt == DRIFT_W'(DRIFT_SCANS - 1)) begin
                drift_cnt <= '0;
                if (drift_up) begin
                    baseline <= baseline + 1'b1;
                end else begin
                    baseline <= baseline - 1'b1;
                end
            end else begin
                drift_cnt <= drift_cnt + 1'b1;
            end
        end
    end

endmodule // tpm_top

/* File: tb/tpm_monitor.sv */
module tpm_monitor import tpm_pkg::*; #(
    parameter int MS_CYCLES = 250000,
    parameter int SAMPLE_W = 12,
    parameter int FREQ_COUNT = 5
) (
    // Clock and reset.
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    // Watched inputs.
    input wire logic I_INT_POLARITY,
    input wire logic I_SLEEP_CMD,
    input wire logic I_SCAN_DONE,
    input wire logic I_TOUCH_DETECTED,
    input wire logic I_NOISE_DETECTED,
    input wire logic [SAMPLE_W-1:0] I_RAW_SAMPLE,
    input wire logic I_DATA_READY,
    // Watched outputs.
    input wire logic O_INT_OUT,
    input wire logic O_INT_OE,
    input wire logic O_SCAN_START,
    input wire logic [1:0] O_MODE,
    input wire logic [$clog2(FREQ_COUNT)-1:0] O_DRIVE_FREQ,
    input wire logic O_FREQ_HOP,
    input wire logic [SAMPLE_W-1:0] O_BASELINE,
    input wire logic O_CALIB_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GREEN_GAP = 40 * MS_CYCLES;
    int oe_cnt;
    int gap;
    logic gv;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) oe_cnt <= 0;
        else oe_cnt <= O_INT_OE ? oe_cnt + 1 : 0;
    end
    // Gap between scan starts, valid only while the mode has stayed slow scanning since the last start.
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            gap <= 0;
            gv <= 1'b0;
        end else if (O_SCAN_START) begin
            gap <= 1;
            gv <= (O_MODE == TPM_GREEN);
        end else begin
            gap <= gap + 1;
            if (O_MODE != TPM_GREEN) gv <= 1'b0;
        end
    end
    a_int_cause: assert property (
        $rose(O_INT_OE) |-> $past(I_DATA_READY) && O_MODE != TPM_SLEEP)
        else $error("notification without data ready");
    a_int_lead: assert property ($rose(O_INT_OE) |-> O_INT_OUT == $past(I_INT_POLARITY))
        else $error("notification idle level wrong");
    a_int_edge: assert property (
        $rose(O_INT_OE) ##4 O_INT_OE |-> O_INT_OUT != $past(O_INT_OUT))
        else $error("notification edge missing");
    a_int_width: assert property ($fell(O_INT_OE) && !$past(I_SLEEP_CMD) |-> oe_cnt == 254)
        else $error("interrupt drive length wrong");
    a_sleep_entry: assert property (
        I_SLEEP_CMD && O_MODE != TPM_SLEEP |=> O_MODE == TPM_SLEEP)
        else $error("sleep command not taken");
    a_sleep_quiet: assert property (O_MODE == TPM_SLEEP |-> !O_SCAN_START && !O_INT_OE)
        else $error("activity while asleep");
    a_green_exit: assert property (
        O_MODE == TPM_GREEN && I_SCAN_DONE && I_TOUCH_DETECTED
        && !I_SLEEP_CMD |=> O_MODE == TPM_NORMAL)
        else $error("touch did not restore normal");
    a_hop_step: assert property (
        I_SCAN_DONE && I_NOISE_DETECTED && O_MODE != TPM_SLEEP |=>
        O_FREQ_HOP && O_DRIVE_FREQ == (($past(O_DRIVE_FREQ) == FREQ_COUNT - 1) ? '0
        : $past(O_DRIVE_FREQ) + 1'b1))
        else $error("frequency hop wrong");
    a_green_gap: assert property (
        O_SCAN_START && gv && O_MODE == TPM_GREEN |-> gap == GREEN_GAP)
        else $error("slow scan interval wrong");
    a_calib_copy: assert property (
        I_SCAN_DONE && !O_CALIB_DONE |=> O_BASELINE == $past(I_RAW_SAMPLE))
        else $error("baseline not copied");
    c_pulse: cover property ($rose(O_INT_OE));
    c_green_back: cover property (O_MODE == TPM_GREEN ##1 O_MODE == TPM_NORMAL);
    c_wake: cover property (O_MODE == TPM_SLEEP ##1 O_MODE == TPM_NORMAL);
endmodule // tpm_monitor

bind tpm_top tpm_monitor #(.MS_CYCLES(MS_CYCLES), .SAMPLE_W(SAMPLE_W), .FREQ_COUNT(FREQ_COUNT))
    u_mon (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_INT_POLARITY(I_INT_POLARITY),
    .I_SLEEP_CMD(I_SLEEP_CMD), .I_SCAN_DONE(I_SCAN_DONE), .I_TOUCH_DETECTED(I_TOUCH_DETECTED),
    .I_NOISE_DETECTED(I_NOISE_DETECTED), .I_RAW_SAMPLE(I_RAW_SAMPLE),
    .I_DATA_READY(I_DATA_READY),
    .O_INT_OUT(O_INT_OUT), .O_INT_OE(O_INT_OE), .O_SCAN_START(O_SCAN_START), .O_MODE(O_MODE),
    .O_DRIVE_FREQ(O_DRIVE_FREQ), .O_FREQ_HOP(O_FREQ_HOP), .O_BASELINE(O_BASELINE),
    .O_CALIB_DONE(O_CALIB_DONE));

/* File: tb/tpm_host_model.sv */
module tpm_host_model (
    // Device side of the shared line.
    input wire logic i_oe,
    input wire logic i_out,
    // Resolved wire level.
    output logic o_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hd_en = 1'b0;
    logic hd_lvl = 1'b1;
    // A released line floats up through the pull-up.
    assign o_wire = i_oe ? i_out : (hd_en ? hd_lvl : 1'b1);
    // The host holds the line low around sleep entry and high to wake.
    task automatic drive(input logic lvl);
        hd_en = 1'b1;
        hd_lvl = lvl;
    endtask
    task automatic rel();
        hd_en = 1'b0;
    endtask
endmodule // tpm_host_model

/* File: tb/tb_top.sv */
module tb_top import tpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic clk = 0, rst_n = 0, sleep = 0, sdone = 0, touch = 0, noise = 0, dready = 0, pol = 0;
    logic [3:0] per = 0, idle = 4'hf;
    logic [11:0] raw = 0, b, ep, base;
    logic int_wire, int_out, int_oe, sstart, hop, cdone;
    logic [1:0] mode, lm = 0;
    logic [2:0] freq;
    logic [11:0] qm[$], qf[$], qp[$];
    int fails = 0, n_tests = 0, n, oc = 0;

    initial forever #2 clk = ~clk;

    tpm_top #(.MS_CYCLES(MS), .WAKE_CYCLES(2 * MS)) DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n),
        .I_NORMAL_PERIOD_MS(per), .I_IDLE_SECONDS(idle), .I_INT_POLARITY(pol),
        .I_SLEEP_CMD(sleep), .I_SCAN_DONE(sdone), .I_TOUCH_DETECTED(touch),
        .I_NOISE_DETECTED(noise), .I_RAW_SAMPLE(raw), .I_DATA_READY(dready),
        .I_INT_IN(int_wire), .O_INT_OUT(int_out), .O_INT_OE(int_oe), .O_SCAN_START(sstart),
        .O_MODE(mode), .O_DRIVE_FREQ(freq), .O_FREQ_HOP(hop), .O_BASELINE(base),
        .O_CALIB_DONE(cdone));
    tpm_host_model u_host (.i_oe(int_oe), .i_out(int_out), .o_wire(int_wire));

    task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [11:0] pop(ref logic [11:0] q[$]);
        return (q.size() != 0) ? q.pop_front() : 12'hxxx;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic scan(input logic t, input logic ns, input logic [11:0] r);
        touch = t;
        noise = ns;
        raw = r;
        sdone = 1'b1;
        @(negedge clk);
        sdone = 1'b0;
        @(negedge clk);
    endtask
    task automatic ready();
        dready = 1'b1;
        @(negedge clk);
        dready = 1'b0;
        @(negedge clk);
    endtask
    task automatic gap(output int k);
        k = 0;
        while (sstart !== 1'b1 && k < 999) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (sstart !== 1'b1 && k < 999);
    endtask
    task automatic wmode(input logic [1:0] m, input int lim);
        n = 0;
        while (mode !== m && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Every mode change, hop and first-cycle notification level seen at the outputs is matched against the oldest note.
    always @(negedge clk) begin
        if (rst_n) begin
            if (mode !== lm) chk("mode", pop(qm), 12'(mode));
            if (hop === 1'b1) chk("freq", pop(qf), 12'(freq));
            if (int_oe === 1'b1) begin
                oc++;
                if (oc == 1) begin
                    ep = pop(qp);
                    chk("int_idle", ep, 12'(int_out));
                end
                if (oc == 5) chk("int_edge", 12'(!ep[0]), 12'(int_out));
            end else if (oc != 0) begin
                chk("int_len", 12'h0fe, 12'(oc));
                oc = 0;
            end
            lm = mode;
        end
    end

    initial begin
        #160000;
        fails++;
        final_report();
    end

    initial begin
        void'($urandom(32'h092e85ff));
        per = 4'(7 + $urandom % 4);
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        chk("oe_reset", 12'h000, 12'(int_oe));
        gap(n);
        chk("normal_period", 12'(per * MS), 12'(n));
        b = 12'($urandom % 2048);
        scan(1'b0, 1'b0, b);
        chk("base_init", b, base);
        n = 0;
        while (cdone !== 1'b1 && n < 2500) begin
            @(negedge clk);
            n++;
        end
        chk("calib_done", 12'h001, 12'(cdone));
        for (int i = 1; i <= 8; i++) begin
            scan(1'b0, 1'b0, b + 12'h005);
            chk("drift", (i == 8) ? b + 12'h001 : b, base);
        end
        b = b + 12'h001;
        for (int i = 1; i <= 6; i++) begin
            qf.push_back(12'(i % 5));
            scan(1'b0, 1'b1, b);
        end
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            for (int j = 0; j < 2; j++) begin
                qp.push_back(12'(p));
                scan(j == 0, 1'b0, b);
                ready();
                repeat (300) @(negedge clk);
            end
            ready();
            repeat (20) @(negedge clk);
        end
        idle = 4'h1;
        qm.push_back(12'(TPM_GREEN));
        scan(1'b1, 1'b0, b);
        wmode(TPM_GREEN, 11000);
        chk("idle_time", 12'h001, 12'(n > 9900 && n < 10100));
        gap(n);
        chk("green_period", 12'h190, 12'(n));
        idle = 4'hf;
        qm.push_back(12'(TPM_NORMAL));
        scan(1'b1, 1'b0, b);
        u_host.drive(1'b0);
        repeat (8) @(negedge clk);
        qm.push_back(12'(TPM_SLEEP));
        sleep = 1'b1;
        @(negedge clk);
        sleep = 1'b0;
        repeat (20) @(negedge clk);
        u_host.drive(1'b1);
        repeat (10) @(negedge clk);
        u_host.drive(1'b0);
        repeat (40) @(negedge clk);
        qm.push_back(12'(TPM_NORMAL));
        u_host.drive(1'b1);
        repeat (30) @(negedge clk);
        u_host.rel();
        wmode(TPM_NORMAL, 20);
        chk("notes_left", 12'h000, 12'(qm.size() + qf.size() + qp.size()));
        final_report();
    end
endmodule // tb_top
